// >>> design/intc_pkg.sv
package intc_pkg;

    // ==============================
    // sizes
    localparam int NUM_SRC = 30;
    localparam int NUM_TRAP = 4;
    localparam int FLAG_WIDE = 48;
    localparam int NUM_PRIO_REG = 12;
    localparam int NUM_NIB = 46;
    localparam int VEC_AW = 7;

    // ==============================
    // register offsets
    localparam logic [11:0] OFS_FLAG0 = 12'h000;
    localparam logic [11:0] OFS_EN0 = 12'h00C;
    localparam logic [11:0] OFS_PRIO0 = 12'h018;
    localparam logic [11:0] OFS_TRAPCTL = 12'h048;
    localparam logic [11:0] OFS_EXTCTL = 12'h04C;
    localparam logic [11:0] OFS_CORECTL = 12'h050;
    localparam logic [11:0] OFS_CORESTAT = 12'h054;
    localparam logic [11:0] OFS_TMASK = 12'h058;
    localparam logic [11:0] OFS_IRQSTAT = 12'h05C;
    localparam logic [11:0] OFS_IRQMASK = 12'h060;
    localparam logic [11:0] OFS_VEC_LO = 12'h200;
    localparam logic [11:0] OFS_VEC_HI = 12'h3FC;

    // ==============================
    // field positions
    localparam int NESTDIS_BIT = 15;
    localparam int TMASK_STAT_BIT = 14;
    localparam int ALTVT_BIT = 15;
    localparam int IPL_HI_BIT = 3;
    localparam int ADDRERR_TRAP = 2;
    localparam int EV_ADDRERR = 0;
    localparam int EV_VECLOAD = 1;

    // ==============================
    // values
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [3:0] RST_IPL = 4'h0;
    localparam logic [13:0] RST_TMASK = 14'h0000;
    localparam logic [2:0] TMASK_MAX_LVL = 3'h6;
    localparam logic [3:0] TRAP_LVL_TOP = 4'hF;
    localparam logic [5:0] TRAP_VEC_BASE = 6'h01;
    localparam logic [5:0] SRC_VEC_BASE = 6'h08;
    localparam logic [23:0] VEC_SPACE_END = 24'h00_00FF;

    // ==============================
    // core handshake states
    typedef enum logic [2:0] {
        S_IDLE = 3'b001,
        S_FETCH = 3'b010,
        S_LOAD = 3'b100
    } state_t;

endpackage

// >>> design/vector_mem.sv
`timescale 1ns/10ps
module vector_mem (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // write port
    input wire logic wrEn,
    input wire logic [intc_pkg::VEC_AW-1:0] wrAddr,
    input wire logic [23:0] wrData,
    // registered read ports
    input wire logic [intc_pkg::VEC_AW-1:0] rdAddrA,
    output logic [23:0] rdDataA,
    input wire logic [intc_pkg::VEC_AW-1:0] rdAddrB,
    output logic [23:0] rdDataB
);
    import intc_pkg::*;

    logic [23:0] mem [2**VEC_AW];

    // table storage
    always_ff @(posedge clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
    end

    // read data registers
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rdDataA <= 24'h00_0000;
            rdDataB <= 24'h00_0000;
        end else begin
            rdDataA <= mem[rdAddrA];
            rdDataB <= mem[rdAddrB];
        end
    end

endmodule

// >>> design/intc_top.sv
// Our own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
// Summary of operation
// - arbitrate thirty requests and four traps by priority before the core
// - request flags in three 16-bit registers, set by source, cleared by software
// - per-source enable bits in three 16-bit enable registers
// - flag sets on its event whatever the enable bit says
// - priorities in twelve registers, last uses only low eight bits
// - priority levels one to seven, seven highest
// - priority zero is never serviced
// - cpu level is four bits, top bit in core control, rest in status
// - nesting disable bit 15 blocks any new interrupt while one is served
// - cpu level bits read-only while nesting disable is one
// - timed mask blocks levels six and below, status bit 14 set meanwhile
// - first control register holds trap flags, second holds alternate table select
// - two tables of 64 vectors of 24 bits; service loads pc from the vector
// - normal fetch from vector space raises address error trap
// - vector goes to pc through a 24-bit multiplexer
// - priority in low three bits of each nibble, fourth bit reads zero
// - equal priority: lower interrupt number wins
module intc_top (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // request sources
    input wire logic [intc_pkg::NUM_SRC-1:0] srcReq,
    input wire logic [intc_pkg::NUM_TRAP-1:0] trapReq,
    // core side
    input wire logic fetchValid,
    input wire logic [23:0] fetchAddr,
    input wire logic instrDone,
    input wire logic intAck,
    input wire logic intReturn,
    output logic intPending,
    output logic [5:0] intVecNum,
    output logic [3:0] intLevel,
    output logic pcLoad,
    output logic [23:0] pcVector,
    output logic [3:0] cpuLevel,
    // interrupt to system
    output logic irqOut
);
    import intc_pkg::*;

    // ==============================
    // helpers
    function automatic logic regHit(input logic [11:0] a, input logic [11:0] base,
                                    input int j);
        return a == base + 12'(j * 4);
    endfunction

    function automatic logic [3:0] trapLvl(input int k);
        return TRAP_LVL_TOP - 4'(k);
    endfunction

    // ==============================
    // state
    logic [NUM_SRC-1:0] flag_r;
    logic [NUM_SRC-1:0] flag_nxt;
    logic [NUM_SRC-1:0] en_r;
    logic [2:0] prio_r [FLAG_WIDE];
    logic nestDis_r;
    logic [NUM_TRAP-1:0] trapFlag_r;
    logic [NUM_TRAP-1:0] trapSet;
    logic altSel_r;
    logic [3:0] ipl_r;
    logic [63:0] iplStack_r;
    logic [3:0] depth_r;
    logic [13:0] tmaskCnt_r;
    logic [1:0] irqStat_r;
    logic [1:0] irqMask_r;
    logic [1:0] evSet;
    state_t state_r;
    logic [FLAG_WIDE-1:0] flagWide;
    logic [FLAG_WIDE-1:0] enWide;
    logic apbWr;
    logic apbSetup;
    logic addrErr;
    logic tmaskOn;
    logic [31:0] rdNxt;
    logic hit;
    logic winValid;
    logic winTrap;
    logic [5:0] winIdx;
    logic [5:0] winVec;
    logic [3:0] winLvl;
    logic [23:0] memRdA;
    logic [23:0] memRdB;

    assign apbWr = psel && penable && pready && pwrite;
    assign apbSetup = psel && penable && !pready;
    assign flagWide = {{(FLAG_WIDE-NUM_SRC){1'b0}}, flag_r};
    assign enWide = {{(FLAG_WIDE-NUM_SRC){1'b0}}, en_r};
    assign tmaskOn = tmaskCnt_r != RST_TMASK;
    assign addrErr = fetchValid && (fetchAddr <= VEC_SPACE_END);

    // ==============================
    // vector table
    vector_mem uVec (
        .clk(clk),
        .reset_n(reset_n),
        .wrEn(apbWr && paddr >= OFS_VEC_LO && paddr <= OFS_VEC_HI && paddr[1:0] == 2'h0),
        .wrAddr(paddr[VEC_AW+1:2]),
        .wrData(pwdata[23:0]),
        .rdAddrA(paddr[VEC_AW+1:2]),
        .rdDataA(memRdA),
        .rdAddrB({altSel_r, intVecNum}),
        .rdDataB(memRdB)
    );

    // ==============================
    // request flags: write stores, event set wins
    always_comb begin
        flag_nxt = flag_r;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (apbWr && regHit(paddr, OFS_FLAG0, i / 16)) begin
                flag_nxt[i] = pwdata[i % 16];
            end
        end
        flag_nxt = flag_nxt | srcReq;
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            flag_r <= '0;
        end else begin
            flag_r <= flag_nxt;
        end
    end

    // enable bits
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            en_r <= '0;
        end else begin
            for (int i = 0; i < NUM_SRC; i++) begin
                if (apbWr && regHit(paddr, OFS_EN0, i / 16)) begin
                    en_r[i] <= pwdata[i % 16];
                end
            end
        end
    end

    // priority nibbles, last register only two nibbles
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            for (int n = 0; n < FLAG_WIDE; n++) begin
                prio_r[n] <= 3'h0;
            end
        end else begin
            for (int n = 0; n < NUM_NIB; n++) begin
                if (apbWr && regHit(paddr, OFS_PRIO0, n / 4)) begin
                    prio_r[n] <= pwdata[(n % 4) * 4 +: 3];
                end
            end
        end
    end

    // ==============================
    // trap control and flags
    always_comb begin
        trapSet = trapReq;
        trapSet[ADDRERR_TRAP] = trapReq[ADDRERR_TRAP] | addrErr;
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            nestDis_r <= 1'b0;
            trapFlag_r <= '0;
        end else if (apbWr && paddr == OFS_TRAPCTL) begin
            nestDis_r <= pwdata[NESTDIS_BIT];
            trapFlag_r <= pwdata[NUM_TRAP-1:0] | trapSet;
        end else begin
            trapFlag_r <= trapFlag_r | trapSet;
        end
    end

    // alternate table select
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            altSel_r <= 1'b0;
        end else if (apbWr && paddr == OFS_EXTCTL) begin
            altSel_r <= pwdata[ALTVT_BIT];
        end
    end

    // timed low priority mask counter, counts retired instructions
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            tmaskCnt_r <= RST_TMASK;
        end else if (apbWr && paddr == OFS_TMASK) begin
            tmaskCnt_r <= pwdata[13:0];
        end else if (instrDone && tmaskOn) begin
            tmaskCnt_r <= tmaskCnt_r - 14'h0001;
        end
    end

    // ==============================
    // arbitration
    always_comb begin
        winValid = 1'b0;
        winTrap = 1'b0;
        winIdx = 6'h00;
        winLvl = 4'h0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (flag_r[i] && en_r[i] && prio_r[i] != 3'h0
                && {1'b0, prio_r[i]} > ipl_r
                && !(tmaskOn && prio_r[i] <= TMASK_MAX_LVL)
                && {1'b0, prio_r[i]} >= winLvl) begin
                winValid = 1'b1;
                winIdx = 6'(i);
                winLvl = {1'b0, prio_r[i]};
            end
        end
        for (int k = NUM_TRAP - 1; k >= 0; k--) begin
            if (trapFlag_r[k] && trapLvl(k) > ipl_r) begin
                winValid = 1'b1;
                winTrap = 1'b1;
                winIdx = 6'(k);
                winLvl = trapLvl(k);
            end
        end
        if (nestDis_r && depth_r != 4'h0) begin
            winValid = 1'b0;
        end
    end

    assign winVec = winTrap ? TRAP_VEC_BASE + winIdx : SRC_VEC_BASE + winIdx;

    // ==============================
    // presentation to the core
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            intPending <= 1'b0;
            intVecNum <= 6'h00;
            intLevel <= 4'h0;
        end else if (state_r == S_IDLE && !(intAck && intPending)) begin
            intPending <= winValid;
            intVecNum <= winVec;
            intLevel <= winLvl;
        end else begin
            intPending <= 1'b0;
        end
    end

    // vector fetch handshake
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_r <= S_IDLE;
            pcLoad <= 1'b0;
            pcVector <= 24'h00_0000;
        end else begin
            case (state_r)
                S_IDLE: begin
                    pcLoad <= 1'b0;
                    if (intAck && intPending) begin
                        state_r <= S_FETCH;
                    end
                end
                S_FETCH: begin
                    pcVector <= memRdB;
                    pcLoad <= 1'b1;
                    state_r <= S_LOAD;
                end
                S_LOAD: begin
                    pcLoad <= 1'b0;
                    state_r <= S_IDLE;
                end
                default: begin
                    pcLoad <= 1'b0;
                    state_r <= S_IDLE;
                end
            endcase
        end
    end

    // cpu level with save stack for nesting
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ipl_r <= RST_IPL;
            iplStack_r <= '0;
            depth_r <= 4'h0;
        end else if (state_r == S_IDLE && intAck && intPending) begin
            ipl_r <= intLevel;
            iplStack_r <= {iplStack_r[59:0], ipl_r};
            depth_r <= depth_r + 4'h1;
        end else if (intReturn && depth_r != 4'h0) begin
            ipl_r <= iplStack_r[3:0];
            iplStack_r <= {4'h0, iplStack_r[63:4]};
            depth_r <= depth_r - 4'h1;
        end else if (apbWr && !nestDis_r && paddr == OFS_CORECTL) begin
            ipl_r[IPL_HI_BIT] <= pwdata[IPL_HI_BIT];
        end else if (apbWr && !nestDis_r && paddr == OFS_CORESTAT) begin
            ipl_r[2:0] <= pwdata[2:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cpuLevel <= RST_IPL;
        end else begin
            cpuLevel <= ipl_r;
        end
    end

    // ==============================
    // event status, mask and interrupt line
    assign evSet = {state_r == S_FETCH, addrErr};

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            irqStat_r <= 2'h0;
            irqMask_r <= 2'h0;
            irqOut <= 1'b0;
        end else begin
            if (apbWr && paddr == OFS_IRQSTAT) begin
                irqStat_r <= (irqStat_r & ~pwdata[1:0]) | evSet;
            end else begin
                irqStat_r <= irqStat_r | evSet;
            end
            if (apbWr && paddr == OFS_IRQMASK) begin
                irqMask_r <= pwdata[1:0];
            end
            irqOut <= |(irqStat_r & irqMask_r);
        end
    end

    // ==============================
    // read mux and decode
    always_comb begin
        rdNxt = 32'h0000_0000;
        hit = 1'b0;
        for (int j = 0; j < 3; j++) begin
            if (regHit(paddr, OFS_FLAG0, j)) begin
                hit = 1'b1;
                rdNxt[15:0] = flagWide[j * 16 +: 16];
            end
            if (regHit(paddr, OFS_EN0, j)) begin
                hit = 1'b1;
                rdNxt[15:0] = enWide[j * 16 +: 16];
            end
        end
        for (int r = 0; r < NUM_PRIO_REG; r++) begin
            if (regHit(paddr, OFS_PRIO0, r)) begin
                hit = 1'b1;
                for (int n = 0; n < 4; n++) begin
                    rdNxt[n * 4 +: 4] = {1'b0, prio_r[r * 4 + n]};
                end
            end
        end
        if (paddr == OFS_TRAPCTL) begin
            hit = 1'b1;
            rdNxt[NESTDIS_BIT] = nestDis_r;
            rdNxt[NUM_TRAP-1:0] = trapFlag_r;
        end else if (paddr == OFS_EXTCTL) begin
            hit = 1'b1;
            rdNxt[ALTVT_BIT] = altSel_r;
            rdNxt[TMASK_STAT_BIT] = tmaskOn;
        end else if (paddr == OFS_CORECTL) begin
            hit = 1'b1;
            rdNxt[IPL_HI_BIT] = ipl_r[IPL_HI_BIT];
        end else if (paddr == OFS_CORESTAT) begin
            hit = 1'b1;
            rdNxt[2:0] = ipl_r[2:0];
        end else if (paddr == OFS_TMASK) begin
            hit = 1'b1;
            rdNxt[13:0] = tmaskCnt_r;
        end else if (paddr == OFS_IRQSTAT) begin
            hit = 1'b1;
            rdNxt[1:0] = irqStat_r;
        end else if (paddr == OFS_IRQMASK) begin
            hit = 1'b1;
            rdNxt[1:0] = irqMask_r;
        end else if (paddr >= OFS_VEC_LO && paddr <= OFS_VEC_HI && paddr[1:0] == 2'h0) begin
            hit = 1'b1;
            rdNxt[23:0] = memRdA;
        end
    end

    // apb answer after one wait cycle
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= apbSetup;
            pslverr <= apbSetup && (!hit || paddr[1:0] != 2'h0);
            if (apbSetup && !pwrite) begin
                prdata <= rdNxt;
            end
        end
    end

    // ==============================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    AST_ZERO_PRIO_NEVER: assert property (
        winValid && !winTrap |-> prio_r[winIdx] != 3'h0)
        else $error("zero priority source won arbitration");
    AST_ABOVE_LEVEL: assert property (
        intPending |-> intLevel > $past(ipl_r))
        else $error("presented level not above cpu level");
    AST_FLAG_SETS: assert property (
        srcReq[0] |=> flag_r[0])
        else $error("request did not set its flag");
    AST_NEST_BLOCK: assert property (
        nestDis_r && depth_r != 4'h0 |=> !intPending)
        else $error("new interrupt taken while nesting disabled");
    AST_LEVEL_RO: assert property (
        nestDis_r && !(intAck && intPending) && !intReturn |=> ipl_r == $past(ipl_r))
        else $error("cpu level changed while read-only");
    AST_TMASK_BLOCK: assert property (
        tmaskOn && winValid |-> winLvl > 4'h6)
        else $error("low level taken during timed mask");
    AST_ADDR_ERR: assert property (
        addrErr |=> trapFlag_r[ADDRERR_TRAP] ##1 irqStat_r[EV_ADDRERR])
        else $error("vector space fetch raised no trap");
    AST_VEC_LOAD: assert property (
        state_r == S_IDLE && intAck && intPending |=> !pcLoad ##1 pcLoad ##1 !pcLoad)
        else $error("vector load pulse misplaced");
    AST_TIE_LOW_WINS: assert property (
        winValid && !winTrap && winIdx != 6'h00 && flag_r[0] && en_r[0]
        && prio_r[0] == winLvl[2:0] && !tmaskOn |-> 1'b0)
        else $error("higher number won an equal priority tie");

endmodule

// >>> testbench/core_model.sv
`timescale 1ns/10ps
// ==============================
// core side: takes a presented request after a set delay
module core_model (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // bench control
    input wire logic ackEn,
    input wire logic [3:0] ackDelay,
    // controller side
    input wire logic intPending,
    input wire logic pcLoad,
    output logic intAck
);
    logic [3:0] waitCnt;
    logic busy;

    initial intAck = 1'b0;

    // one ack per request, held off until the pc load is seen
    always @(posedge clk) begin
        intAck <= 1'b0;
        if (!reset_n || pcLoad) begin
            waitCnt <= 4'h0;
            busy <= 1'b0;
        end else if (ackEn && intPending && !busy) begin
            if (waitCnt == ackDelay) begin
                intAck <= 1'b1;
                busy <= 1'b1;
            end
            waitCnt <= waitCnt + 4'h1;
        end
    end
endmodule

// >>> testbench/tb_vectored_priority_interrupt_ctrl.sv
`timescale 1ns/10ps
module tb_vectored_priority_interrupt_ctrl;
    import intc_pkg::*;
    // ==============================
    // signals
    typedef struct packed {
        logic [11:0] a;
        logic [31:0] d;
        logic [31:0] e;
        logic err;
    } reg_row_t;
    typedef struct packed {
        logic [2:0] cpu;
        logic [29:0] req;
        logic p;
        logic [5:0] v;
        logic [3:0] l;
    } arb_row_t;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, errv;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rdv;
    logic pready, pslverr, intPending, pcLoad, irqOut, intAck;
    logic [29:0] srcReq = '0;
    logic [3:0] trapReq = 4'h0, ackDelay = 4'h3;
    logic fetchValid = 1'b0, instrDone = 1'b0, intReturn = 1'b0, ackEn = 1'b0;
    logic [23:0] fetchAddr = 24'h00_0000, pcVector;
    logic [5:0] intVecNum;
    logic [3:0] intLevel, cpuLevel;
    int bad_count = 0, compares = 0, cyc = 0;
    reg_row_t regRows [15] = '{
        '{12'h00C, 32'hFFFF_FFFF, 32'h0000_FFFF, 1'b0},
        '{12'h020, 32'h0000_FFFF, 32'h0000_7777, 1'b0},
        '{12'h044, 32'h0000_FFFF, 32'h0000_0077, 1'b0},
        '{12'h054, 32'h0000_00FF, 32'h0000_0007, 1'b0},
        '{12'h050, 32'h0000_FFFF, 32'h0000_0008, 1'b0},
        '{12'h050, 32'h0000_0000, 32'h0000_0000, 1'b0},
        '{12'h04C, 32'h0000_4000, 32'h0000_0000, 1'b0},
        '{12'h048, 32'h0000_8000, 32'h0000_8000, 1'b0},
        '{12'h048, 32'h0000_0000, 32'h0000_0000, 1'b0},
        '{12'h064, 32'h0000_FFFF, 32'h0000_0000, 1'b1},
        '{12'h002, 32'h0000_FFFF, 32'h0000_0000, 1'b1},
        '{12'h018, 32'h0000_5440, 32'h0000_5440, 1'b0},
        '{12'h01C, 32'h0000_0076, 32'h0000_0076, 1'b0},
        '{12'h00C, 32'h0000_001F, 32'h0000_001F, 1'b0},
        '{12'h22C, 32'h00AB_CDEF, 32'h00AB_CDEF, 1'b0}
    };
    arb_row_t arbRows [7] = '{
        '{3'h0, 30'h01, 1'b0, 6'h00, 4'h0},
        '{3'h0, 30'h20, 1'b0, 6'h00, 4'h0},
        '{3'h0, 30'h06, 1'b1, 6'h09, 4'h4},
        '{3'h0, 30'h1E, 1'b1, 6'h0C, 4'h6},
        '{3'h5, 30'h0A, 1'b0, 6'h00, 4'h0},
        '{3'h5, 30'h10, 1'b1, 6'h0C, 4'h6},
        '{3'h0, 30'h08, 1'b1, 6'h0B, 4'h5}
    };

    // ==============================
    // design and core
    intc_top u_intc_top (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .srcReq, .trapReq, .fetchValid, .fetchAddr,
        .instrDone, .intAck, .intReturn, .intPending, .intVecNum, .intLevel, .pcLoad,
        .pcVector, .cpuLevel, .irqOut);
    core_model u_core_model (.clk, .reset_n, .ackEn, .ackDelay, .intPending, .pcLoad,
        .intAck);

    // clock and hang guard
    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            bad_count++;
            end_sim();
        end
    end

    // ==============================
    // tasks
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic pulse(input logic [29:0] m);
        @(posedge clk);
        srcReq <= m;
        @(posedge clk);
        srcReq <= '0;
        repeat (3) @(posedge clk);
    endtask
    task automatic pchk(input logic p, input logic [5:0] v, input logic [3:0] l);
        check({31'h0, intPending}, {31'h0, p});
        if (p) begin
            check({26'h0, intVecNum}, {26'h0, v});
            check({28'h0, intLevel}, {28'h0, l});
        end
    endtask
    task automatic end_sim();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ==============================
    // main sequence
    initial begin
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        check({26'h0, intPending, irqOut, cpuLevel}, 32'h0);
        apb(1'b0, OFS_TRAPCTL, 32'h0);
        check(rdv, 32'h0);
        $display("reset test done");
        foreach (regRows[i]) begin
            apb(1'b1, regRows[i].a, regRows[i].d);
            apb(1'b0, regRows[i].a, 32'h0);
            check({31'h0, errv}, {31'h0, regRows[i].err});
            check(rdv, regRows[i].e);
        end
        $display("register test done");
        foreach (arbRows[i]) begin
            apb(1'b1, OFS_CORESTAT, {29'h0, arbRows[i].cpu});
            pulse(arbRows[i].req);
            pchk(arbRows[i].p, arbRows[i].v, arbRows[i].l);
            apb(1'b0, OFS_FLAG0, 32'h0);
            check(rdv, {16'h0, arbRows[i].req[15:0]});
            apb(1'b1, OFS_FLAG0, 32'h0);
        end
        $display("arbitration test done");
        // service under nesting disable
        apb(1'b1, OFS_TRAPCTL, 32'h0000_8000);
        apb(1'b1, OFS_CORESTAT, 32'h0000_0003);
        apb(1'b0, OFS_CORESTAT, 32'h0);
        check(rdv, 32'h0);
        ackEn <= 1'b1;
        pulse(30'h08);
        do @(posedge clk); while (pcLoad !== 1'b1);
        ackEn <= 1'b0;
        check({8'h0, pcVector}, 32'h00AB_CDEF);
        repeat (2) @(posedge clk);
        check({28'h0, cpuLevel}, 32'h5);
        pulse(30'h10);
        pchk(1'b0, 6'h00, 4'h0);
        intReturn <= 1'b1;
        @(posedge clk);
        intReturn <= 1'b0;
        repeat (3) @(posedge clk);
        pchk(1'b1, 6'h0C, 4'h6);
        apb(1'b1, OFS_TRAPCTL, 32'h0);
        apb(1'b1, OFS_FLAG0, 32'h0);
        $display("service test done");
        // timed mask of levels six and below
        apb(1'b1, OFS_TMASK, 32'h0000_0002);
        apb(1'b0, OFS_EXTCTL, 32'h0);
        check(rdv, 32'h0000_4000);
        pulse(30'h10);
        pchk(1'b0, 6'h00, 4'h0);
        instrDone <= 1'b1;
        repeat (2) @(posedge clk);
        instrDone <= 1'b0;
        repeat (3) @(posedge clk);
        pchk(1'b1, 6'h0C, 4'h6);
        // service the pending source through the alternate table
        apb(1'b1, OFS_EXTCTL, 32'h0000_8000);
        apb(1'b1, 12'h330, 32'h0012_3456);
        ackEn <= 1'b1;
        do @(posedge clk); while (pcLoad !== 1'b1);
        ackEn <= 1'b0;
        check({8'h0, pcVector}, 32'h0012_3456);
        apb(1'b1, OFS_FLAG0, 32'h0);
        $display("timed mask test done");
        // fetches just outside and at the bottom of vector space
        apb(1'b1, OFS_IRQSTAT, 32'h0000_0003);
        apb(1'b1, OFS_IRQMASK, 32'h0000_0001);
        for (int i = 0; i < 2; i++) begin
            if (i < 2) begin
                @(posedge clk);
                fetchValid <= 1'b1;
                fetchAddr <= (i == 0) ? 24'h00_0100 : 24'h00_0000;
                @(posedge clk);
                fetchValid <= 1'b0;
                repeat (4) @(posedge clk);
                apb(1'b0, OFS_TRAPCTL, 32'h0);
                check(rdv, (i == 0) ? 32'h0 : 32'h0000_0004);
                check({31'h0, irqOut}, {31'h0, i == 1});
            end
        end
        pchk(1'b1, 6'h03, 4'hD);
        // a higher trap overtakes the pending address error
        trapReq <= 4'h1;
        @(posedge clk);
        trapReq <= 4'h0;
        repeat (3) @(posedge clk);
        pchk(1'b1, 6'h01, 4'hF);
        apb(1'b1, OFS_TRAPCTL, 32'h0);
        apb(1'b1, OFS_IRQSTAT, 32'h0000_0001);
        repeat (3) @(posedge clk);
        check({31'h0, irqOut}, 32'h0);
        $display("address error test done");
        // reset in mid-run brings level and enables back to zero
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        check({26'h0, intPending, irqOut, cpuLevel}, 32'h0);
        apb(1'b0, OFS_EN0, 32'h0);
        check(rdv, 32'h0);
        $display("mid-run reset test done");
        end_sim();
    end
endmodule
